/* File: two_wire_debug_address_select.sv */
// device end of the two-wire debug port: link engine, target select and crossing
`timescale 1ns/1ps
module two_wire_debug_address_select
  import debug_port_pkg::*;
#(
  // identification bytes: values are arbitrary
  parameter logic [7:0] DEVICE_ID = 8'h5a,
  parameter logic [7:0] REVISION_ID = 8'h01
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic DEBUG_LINK_CLOCK,
  input wire logic DEBUG_LINK_DATA_I,
  output logic DEBUG_LINK_DATA_O,
  output logic DEBUG_LINK_DATA_OE,
  input wire logic FLASH_RD_VALID,
  input wire logic [7:0] FLASH_RD_BYTE,
  output logic [7:0] FLASH_CTRL,
  output logic [7:0] FLASH_DATA,
  output logic FLASH_CTRL_STB,
  output logic FLASH_DATA_STB
);

  // ==========================================================================
  // reset brought into the link domain
  logic lrst_s1_q, lrst_s2_q, lrst_s3_q;

  always_ff @(posedge DEBUG_LINK_CLOCK)
  begin
    lrst_s1_q <= RST_B;
    lrst_s2_q <= lrst_s1_q;
    lrst_s3_q <= lrst_s2_q;
  end

  // ==========================================================================
  // link engine, runs on every rising host clock edge, idle ones between frames included
  link_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] cmd_q, cmd_d;
  logic [7:0] shreg_q, shreg_d;
  logic [7:0] target_select_q, target_select_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wr_q, wr_d;
  logic req_q, req_d;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic ack_toggle_q, ack_toggle_d;
  logic go;
  logic done;
  logic [1:0] cmd_full;
  logic [7:0] shift_in_full;
  logic [7:0] rd_word;

  assign done = (ack_s3_q == req_q);
  assign cmd_full = {DEBUG_LINK_DATA_I, cmd_q[1]};
  assign shift_in_full = {DEBUG_LINK_DATA_I, shreg_q[7:1]};

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    shreg_d = shreg_q;
    target_select_d = target_select_q; // see R9
    wbyte_d = wbyte_q;
    wr_d = wr_q;
    req_d = req_q;
    case (state_q)
      L_IDLE:
      begin
        cnt_d = 3'h0;
        if (!DEBUG_LINK_DATA_I)
        begin
          state_d = L_CMD;
        end
      end
      L_CMD:
      begin
        cmd_d = cmd_full;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CMD_LAST_BIT)
        begin
          cnt_d = 3'h0;
          if (cmd_full == CMD_ADDR_RD)
          begin
            shreg_d = target_select_q; // see R2
            state_d = L_SHIFT_OUT;
          end
          else if (cmd_full == CMD_DATA_RD)
          begin
            wr_d = 1'b0;
            req_d = ~req_q; // see R3
            state_d = L_WAIT;
          end
          else
          begin
            state_d = L_SHIFT_IN;
          end
        end
      end
      L_SHIFT_IN:
      begin
        shreg_d = shift_in_full;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == BYTE_LAST_BIT)
        begin
          cnt_d = 3'h0;
          if (cmd_q == CMD_ADDR_WR)
          begin
            target_select_d = shift_in_full; // see R2
            state_d = L_IDLE;
          end
          else
          begin
            wbyte_d = shift_in_full;
            wr_d = 1'b1;
            req_d = ~req_q; // see R3
            state_d = L_WAIT;
          end
        end
      end
      L_WAIT:
      begin
        if (done)
        begin
          if (wr_q)
          begin
            state_d = L_IDLE;
          end
          else
          begin
            shreg_d = rd_word;
            state_d = L_SHIFT_OUT;
          end
        end
      end
      L_SHIFT_OUT:
      begin
        shreg_d = {1'b0, shreg_q[7:1]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == BYTE_LAST_BIT)
        begin
          cnt_d = 3'h0;
          state_d = L_IDLE;
        end
      end
      default:
      begin
        state_d = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge DEBUG_LINK_CLOCK)
  begin
    if (!lrst_s3_q)
    begin
      state_q <= L_IDLE;
      cnt_q <= 3'h0;
      cmd_q <= CMD_DATA_RD;
      shreg_q <= 8'h00;
      target_select_q <= TARGET_SELECT_RESET; // see R2
      wbyte_q <= 8'h00;
      wr_q <= 1'b0;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      shreg_q <= shreg_d;
      target_select_q <= target_select_d;
      wbyte_q <= wbyte_d;
      wr_q <= wr_d;
      req_q <= req_d;
      ack_s1_q <= ack_toggle_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // ==========================================================================
  // data line drive: busy low, ready high, then read bits lsb first
  always_comb
  begin
    DEBUG_LINK_DATA_OE = 1'b0; // see R1
    DEBUG_LINK_DATA_O = 1'b0;
    if (state_q == L_WAIT)
    begin
      DEBUG_LINK_DATA_OE = 1'b1;
      DEBUG_LINK_DATA_O = done;
    end
    else if (state_q == L_SHIFT_OUT)
    begin
      DEBUG_LINK_DATA_OE = 1'b1;
      DEBUG_LINK_DATA_O = shreg_q[0];
    end
  end

  // ==========================================================================
  // request crossing into the system clock; select, flag and byte stay held
  assign go = req_s2_q ^ req_s3_q;

  always_comb
  begin
    ack_toggle_d = ack_toggle_q;
    if (go)
    begin
      ack_toggle_d = ~ack_toggle_q;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_toggle_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_toggle_q <= ack_toggle_d;
    end
  end

  // ==========================================================================
  // targets, reached from the link engine above and, for the data register, from the flash read port
  debug_target_regs #(
    .DEVICE_ID(DEVICE_ID),
    .REVISION_ID(REVISION_ID)
  ) u_targets (
    .clk(MCLK),
    .rst_n(RST_B),
    .go(go), // see R8
    .write(wr_q),
    .sel(target_select_q), // see R3
    .wdata(wbyte_q),
    .core_load(FLASH_RD_VALID),
    .core_byte(FLASH_RD_BYTE),
    .rdata(rd_word),
    .flash_ctrl(FLASH_CTRL),
    .flash_data(FLASH_DATA),
    .ctrl_stb(FLASH_CTRL_STB),
    .data_stb(FLASH_DATA_STB)
  );

endmodule : two_wire_debug_address_select

/* File: debug_port_pkg.sv */
// constants shared by the two-wire debug port and its target registers
//
// Notes on behaviour
// R1: two lines carry all transfers: a host-driven clock and one shared two-way data line.
// R2: the 8-bit target select register is readable, writable over the link, zero after reset.
// R3: every data read or write goes to the register named by the target select.
// R4: code 00 makes a data read return the device identification byte.
// R5: code 01 makes a data read return the revision identification byte.
// R6: code 02 lets data reads and writes reach the flash programming control register.
// R7: code b4 lets data reads and writes reach the flash programming data register.
// R8: the host reaches these registers only through link transfers, never the internal bus.
// R9: the target select keeps its value between data commands until the host rewrites it.
package debug_port_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W = 3;
  localparam int unsigned CMD_W = 2;

  // ==========================================================================
  // target codes held in the target select register
  localparam logic [7:0] SEL_DEVICE_ID = 8'h00;
  localparam logic [7:0] SEL_REVISION_ID = 8'h01;
  localparam logic [7:0] SEL_FLASH_CTRL = 8'h02;
  localparam logic [7:0] SEL_FLASH_DATA = 8'hb4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] TARGET_SELECT_RESET = 8'h00;
  localparam logic [7:0] FLASH_CTRL_RESET = 8'h00;
  localparam logic [7:0] FLASH_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // link commands, sent lsb first after the start bit
  localparam logic [1:0] CMD_DATA_RD = 2'h0;
  localparam logic [1:0] CMD_DATA_WR = 2'h1;
  localparam logic [1:0] CMD_ADDR_RD = 2'h2;
  localparam logic [1:0] CMD_ADDR_WR = 2'h3;

  // ==========================================================================
  // bit counts within a frame
  localparam logic [2:0] CMD_LAST_BIT = 3'h1;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    L_IDLE,
    L_CMD,
    L_SHIFT_IN,
    L_WAIT,
    L_SHIFT_OUT
  } link_state_t;

endpackage : debug_port_pkg

/* File: debug_target_regs.sv */
// data registers that the debug link reaches through the target select
`timescale 1ns/1ps
module debug_target_regs
  import debug_port_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a,
  parameter logic [7:0] REVISION_ID = 8'h01
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic write,
  input wire logic [7:0] sel,
  input wire logic [7:0] wdata,
  input wire logic core_load,
  input wire logic [7:0] core_byte,
  output logic [7:0] rdata,
  output logic [7:0] flash_ctrl,
  output logic [7:0] flash_data,
  output logic ctrl_stb,
  output logic data_stb
);

  logic [7:0] rdata_q, rdata_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] data_q, data_d;
  logic ctrl_stb_q, ctrl_stb_d;
  logic data_stb_q, data_stb_d;

  // ==========================================================================
  // decode of the selected target
  always_comb
  begin
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    data_d = data_q;
    ctrl_stb_d = 1'b0;
    data_stb_d = 1'b0;
    // the core may refill the data register, a host write in the same cycle wins
    if (core_load)
    begin
      data_d = core_byte;
    end
    if (go)
    begin
      if (sel == SEL_DEVICE_ID)
      begin
        rdata_d = DEVICE_ID; // see R4
      end
      else if (sel == SEL_REVISION_ID)
      begin
        rdata_d = REVISION_ID; // see R5
      end
      else if (sel == SEL_FLASH_CTRL)
      begin
        if (write)
        begin
          ctrl_d = wdata; // see R6
          ctrl_stb_d = 1'b1;
          rdata_d = wdata;
        end
        else
        begin
          rdata_d = ctrl_q; // see R6
        end
      end
      else if (sel == SEL_FLASH_DATA)
      begin
        if (write)
        begin
          data_d = wdata; // see R7
          data_stb_d = 1'b1;
          rdata_d = wdata;
        end
        else
        begin
          rdata_d = data_q; // see R7
        end
      end
      else
      begin
        rdata_d = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_q <= UNMAPPED_READ;
      ctrl_q <= FLASH_CTRL_RESET;
      data_q <= FLASH_DATA_RESET;
      ctrl_stb_q <= 1'b0;
      data_stb_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      ctrl_stb_q <= ctrl_stb_d;
      data_stb_q <= data_stb_d;
    end
  end

  assign rdata = rdata_q;
  assign flash_ctrl = ctrl_q;
  assign flash_data = data_q;
  assign ctrl_stb = ctrl_stb_q;
  assign data_stb = data_stb_q;

endmodule : debug_target_regs

/* File: debug_port_chk.sv */
// checker for the device end of the two-wire debug port
`timescale 1ns/1ps
module debug_port_chk
  import debug_port_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic DEBUG_LINK_CLOCK,
  input wire logic DEBUG_LINK_DATA_I,
  input wire logic DEBUG_LINK_DATA_O,
  input wire logic DEBUG_LINK_DATA_OE,
  input wire logic FLASH_RD_VALID,
  input wire logic [7:0] FLASH_RD_BYTE,
  input wire logic [7:0] FLASH_CTRL,
  input wire logic [7:0] FLASH_DATA,
  input wire logic FLASH_CTRL_STB,
  input wire logic FLASH_DATA_STB
);
  // ==========================================================================
  // link answer steps
  sequence s_drive3;
    DEBUG_LINK_DATA_OE [*3];
  endsequence
  sequence s_release;
    ##[1:40] !DEBUG_LINK_DATA_OE;
  endsequence

  // ==========================================================================
  // assertions
  chk_reset_clears: assert property (@(posedge MCLK) !RST_B |=> FLASH_CTRL == 8'h00 &&
    FLASH_DATA == 8'h00 && !FLASH_CTRL_STB && !FLASH_DATA_STB) else $error("outputs not cleared by reset");
  chk_link_reset: assert property (@(posedge DEBUG_LINK_CLOCK) !RST_B [*4] |=> !DEBUG_LINK_DATA_OE)
    else $error("link drives while in reset");
  chk_ctrl_by_stb: assert property (@(posedge MCLK) disable iff (!RST_B) $changed(FLASH_CTRL) |-> FLASH_CTRL_STB)
    else $error("control changed without strobe");
  chk_ctrl_pulse: assert property (@(posedge MCLK) disable iff (!RST_B) FLASH_CTRL_STB |=> !FLASH_CTRL_STB)
    else $error("control strobe too long");
  chk_data_pulse: assert property (@(posedge MCLK) disable iff (!RST_B) FLASH_DATA_STB |=> !FLASH_DATA_STB)
    else $error("data strobe too long");
  chk_data_cause: assert property (@(posedge MCLK) disable iff (!RST_B)
    $changed(FLASH_DATA) |-> FLASH_DATA_STB || $past(FLASH_RD_VALID)) else $error("data changed without cause");
  chk_core_load: assert property (@(posedge MCLK) disable iff (!RST_B)
    FLASH_RD_VALID |=> FLASH_DATA_STB || FLASH_DATA == $past(FLASH_RD_BYTE)) else $error("core byte not loaded");
  chk_out_quiet: assert property (@(posedge DEBUG_LINK_CLOCK) disable iff (!RST_B)
    !DEBUG_LINK_DATA_OE |-> !DEBUG_LINK_DATA_O) else $error("output high while released");
  chk_drive_min: assert property (@(posedge DEBUG_LINK_CLOCK) disable iff (!RST_B)
    $rose(DEBUG_LINK_DATA_OE) |-> s_drive3) else $error("answer too short");
  chk_drive_ends: assert property (@(posedge DEBUG_LINK_CLOCK) disable iff (!RST_B)
    $rose(DEBUG_LINK_DATA_OE) |-> s_release) else $error("line never released");
endmodule : debug_port_chk

bind two_wire_debug_address_select debug_port_chk u_chk (.MCLK, .RST_B, .DEBUG_LINK_CLOCK, .DEBUG_LINK_DATA_I,
  .DEBUG_LINK_DATA_O, .DEBUG_LINK_DATA_OE, .FLASH_RD_VALID, .FLASH_RD_BYTE, .FLASH_CTRL, .FLASH_DATA,
  .FLASH_CTRL_STB, .FLASH_DATA_STB);

/* File: debug_host_model.sv */
// host end of the two-wire link: makes the link clock and sends frames
`timescale 1ns/1ps
module debug_host_model
  import debug_port_pkg::*;
(
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic lclk,
  output logic line,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  logic host_o = 1'b1;
  logic host_oe = 1'b0;
  initial lclk = 1'b0;
  initial rx_stb = 1'b0;
  // a released line shows the inverse of the host's last level
  assign line = dev_oe ? dev_o : (host_oe ? host_o : ~host_o);

  // one link cycle: drive after the fall, sample just before the rise
  task automatic cyc(input logic v, output logic s);
    host_o = v;
    #37 s = line;
    lclk = 1'b1;
    #40 lclk = 1'b0;
    #3;
  endtask : cyc

  task automatic tick(input int n);
    logic s;
    // host holds the line high while idle
    host_oe = 1'b1;
    repeat (n) cyc(1'b1, s);
  endtask : tick

  // start bit, command lsb first, write byte, busy/ready wait, read byte
  task automatic frame(input logic [1:0] cmd, input logic [7:0] wb, output logic ok);
    logic s;
    logic [7:0] rb;
    int k;
    ok = 1'b1;
    host_oe = 1'b1;
    cyc(1'b0, s);
    cyc(cmd[0], s);
    cyc(cmd[1], s);
    if (cmd[0])
      for (int i = 0; i < 8; i++) cyc(wb[i], s);
    host_oe = 1'b0;
    // only data commands get busy and ready
    if (!cmd[1])
    begin
      k = 0;
      cyc(host_o, s);
      while (s !== 1'b1 && k < 40)
      begin
        k++;
        cyc(host_o, s);
      end
      ok = (k < 40);
    end
    if (!cmd[0])
    begin
      for (int i = 0; i < 8; i++)
      begin
        cyc(host_o, s);
        rb[i] = s;
      end
      rx_byte = rb;
      rx_stb = 1'b1;
      #1 rx_stb = 1'b0;
    end
    // back to idle high, so no false start bit follows
    host_o = 1'b1;
    host_oe = 1'b1;
  endtask : frame
endmodule : debug_host_model

/* File: testbench.sv */
// self-checking bench for the device end of the two-wire debug port
`timescale 1ns/1ps
module testbench;
  import debug_port_pkg::*;
  localparam logic [7:0] ID_DEV = 8'h3c; // arbitrary
  localparam logic [7:0] ID_REV = 8'h07; // arbitrary
  logic MCLK, RST_B, FLASH_RD_VALID;
  logic [7:0] FLASH_RD_BYTE, FLASH_CTRL, FLASH_DATA, rx_byte, v;
  logic FLASH_CTRL_STB, FLASH_DATA_STB, DEBUG_LINK_DATA_O, DEBUG_LINK_DATA_OE, rx_stb;
  wire logic DEBUG_LINK_CLOCK, DEBUG_LINK_DATA_I;
  int err_count = 0, checks_done = 0;
  logic [7:0] exp_q[$], wr_q[$];
  logic [7:0] codes[5] = '{SEL_DEVICE_ID, SEL_REVISION_ID, SEL_FLASH_CTRL, SEL_FLASH_DATA, 8'hb5};

  two_wire_debug_address_select #(.DEVICE_ID(ID_DEV), .REVISION_ID(ID_REV)) u_dut (.MCLK, .RST_B,
    .DEBUG_LINK_CLOCK, .DEBUG_LINK_DATA_I, .DEBUG_LINK_DATA_O, .DEBUG_LINK_DATA_OE, .FLASH_RD_VALID,
    .FLASH_RD_BYTE, .FLASH_CTRL, .FLASH_DATA, .FLASH_CTRL_STB, .FLASH_DATA_STB);
  debug_host_model u_host (.dev_o(DEBUG_LINK_DATA_O), .dev_oe(DEBUG_LINK_DATA_OE), .lclk(DEBUG_LINK_CLOCK),
    .line(DEBUG_LINK_DATA_I), .rx_byte(rx_byte), .rx_stb(rx_stb));

  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic op(input logic [1:0] cmd, input logic [7:0] wb);
    logic ok;
    u_host.frame(cmd, wb, ok);
    check({7'h00, ok}, 8'h01);
  endtask : op

  // ==========================================================================
  // watchers take the oldest note per result
  always @(posedge rx_stb) check(rx_byte, exp_q.pop_front());
  always @(posedge MCLK)
    if (FLASH_CTRL_STB === 1'b1 || FLASH_DATA_STB === 1'b1)
      check(FLASH_CTRL_STB ? FLASH_CTRL : FLASH_DATA, wr_q.pop_front());

  initial
  begin
    #400000 err_count++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    RST_B = 1'b0;
    FLASH_RD_VALID = 1'b0;
    FLASH_RD_BYTE = 8'h00;
    void'($urandom(32'h82ed057e));
    u_host.tick(4);
    @(posedge MCLK) RST_B <= 1'b1;
    u_host.tick(3);
    exp_q.push_back(TARGET_SELECT_RESET);
    op(CMD_ADDR_RD, 8'h00);
    foreach (codes[i])
    begin
      v = 8'($urandom);
      op(CMD_ADDR_WR, codes[i]);
      exp_q.push_back(codes[i]);
      op(CMD_ADDR_RD, 8'h00);
      if (codes[i] == SEL_FLASH_CTRL || codes[i] == SEL_FLASH_DATA) wr_q.push_back(v);
      op(CMD_DATA_WR, v);
      v = (codes[i] == SEL_DEVICE_ID) ? ID_DEV : (codes[i] == SEL_REVISION_ID) ? ID_REV :
        (codes[i] == 8'hb5) ? UNMAPPED_READ : v;
      repeat (2) exp_q.push_back(v);
      repeat (2) op(CMD_DATA_RD, 8'h00);
    end
    v = 8'($urandom);
    @(posedge MCLK)
    begin
      FLASH_RD_VALID <= 1'b1;
      FLASH_RD_BYTE <= v;
    end
    @(posedge MCLK) FLASH_RD_VALID <= 1'b0;
    op(CMD_ADDR_WR, SEL_FLASH_DATA);
    exp_q.push_back(v);
    op(CMD_DATA_RD, 8'h00);
    repeat (20) @(posedge MCLK);
    check(exp_q.size() + wr_q.size(), 8'h00);
    print_verdict();
  end
endmodule : testbench
